// [src/cil_pkg.sv]
package cil_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_FAMILY = 8'h00;
  localparam logic [7:0] ADDR_CHIP   = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int RUN_BIT  = 0;
  localparam int REV_LSB  = 1;
  localparam int CHIP_LSB = 4;
  localparam int STS_ABSENT = 0;
  localparam int STS_BAD    = 1;
  localparam int STS_LOADED = 2;
  localparam int STS_RUN    = 3;

  // ------------------------------------------------------------
  // Reset values and EEPROM layout
  // ------------------------------------------------------------
  localparam logic       RUN_RST       = 1'h0;
  localparam logic [7:0] EE_ADDR_ID0   = 8'h00;
  localparam logic [7:0] EE_ADDR_ID1   = 8'h01;
  localparam logic [7:0] EE_ADDR_FIRST = 8'h02;
  localparam logic [1:0] STRAP_AUTO    = 2'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int EE_WAIT_NS    = 100000;
  localparam int EE_WAIT_CYC   = EE_WAIT_NS / CLK_PERIOD_NS;
  localparam int SYNC_SETTLE   = 2;

  // ------------------------------------------------------------
  // Start-up sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_STRAP   = 3'h0,
    S_WAIT_SW = 3'h1,
    S_ID0     = 3'h2,
    S_ID1     = 3'h3,
    S_LOAD    = 3'h4,
    S_RUN     = 3'h5
  } cil_state_t;

endpackage

// [src/cil_top.sv]
// Contract
// - Non-zero strap mode: switch starts only after software writes run bit one.
// - Non-zero strap mode with run bit zero: switch stays stopped.
// - Strap mode zero: try EEPROM first, then start without run bit write.
// - No EEPROM answer: keep strap and built-in default register values.
// - EEPROM present: byte 0 must match family, byte 1 [7:4] chip code.
// - Identification passes: EEPROM contents are written over register defaults.
// - Register one: read-only chip code bits 7-4, revision bits 3-1.
module cil_top #(
  parameter logic [7:0] FAMILY_CODE = 8'hA5,  // Arbitrary value
  parameter logic [3:0] CHIP_CODE   = 4'h5,   // Arbitrary value
  parameter logic [2:0] REVISION    = 3'h2,   // Arbitrary value
  parameter logic [7:0] LOAD_LAST   = 8'h0B,
  parameter int         EE_WAIT     = cil_pkg::EE_WAIT_CYC
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // Strap pins
  input  wire logic       i_strap_mode_pin_high,
  input  wire logic       i_strap_mode_pin_low,
  // Register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  // EEPROM byte reader
  output logic            o_ee_rd,
  output logic      [7:0] o_ee_addr,
  input  wire logic       i_ee_ack,
  input  wire logic [7:0] i_ee_data,
  // Register loading
  output logic            o_cfg_wr,
  output logic      [7:0] o_cfg_addr,
  output logic      [7:0] o_cfg_data,
  // Status
  output logic            o_use_defaults,
  output logic            o_switch_run
);
  import cil_pkg::*;

  localparam int CW = $clog2(EE_WAIT + SYNC_SETTLE + 1);

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (EE_WAIT < 1) begin : g_bad_wait
    $error("EE_WAIT must be at least one cycle");
  end
  if (LOAD_LAST < EE_ADDR_FIRST) begin : g_bad_last
    $error("LOAD_LAST below first loadable address");
  end

  cil_state_t       st_ff;
  cil_state_t       nxt_st;
  logic [1:0]       strap_s1_ff;
  logic [1:0]       strap_s2_ff;
  logic [1:0]       mode_ff;
  logic [CW-1:0]    wcnt_ff;
  logic             run_ff;
  logic             absent_ff;
  logic             bad_ff;
  logic             loaded_ff;
  logic [7:0]       ee_addr_ff;
  logic             cfg_wr_ff;
  logic [7:0]       cfg_addr_ff;
  logic [7:0]       cfg_data_ff;
  logic [7:0]       rdata_ff;
  logic             swrun_ff;
  logic             reading;
  logic             timeout;
  logic             wr_chip;

  // ------------------------------------------------------------
  // Strap synchroniser
  // ------------------------------------------------------------
  // Two flops per pin, no reset; the sequencer waits out the settle time
  always_ff @(posedge i_clk_sys) begin
    strap_s1_ff <= {i_strap_mode_pin_high, i_strap_mode_pin_low};
    strap_s2_ff <= strap_s1_ff;
  end

  // ------------------------------------------------------------
  // Start-up sequencer
  // ------------------------------------------------------------
  assign reading = (st_ff == S_ID0) || (st_ff == S_ID1) || (st_ff == S_LOAD);
  assign timeout = reading && !i_ee_ack && (wcnt_ff == CW'(EE_WAIT - 1));
  assign wr_chip = i_reg_wr && (i_reg_addr == ADDR_CHIP);

  // Next state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      S_STRAP: begin
        if (wcnt_ff == CW'(SYNC_SETTLE)) begin
          nxt_st = (strap_s2_ff == STRAP_AUTO) ? S_ID0 : S_WAIT_SW;
        end
      end
      S_WAIT_SW: begin
        if (run_ff) begin
          nxt_st = S_RUN;
        end
      end
      S_ID0: begin
        if (i_ee_ack) begin
          nxt_st = (i_ee_data == FAMILY_CODE) ? S_ID1 : S_RUN;
        end else if (timeout) begin
          nxt_st = S_RUN;
        end
      end
      S_ID1: begin
        if (i_ee_ack) begin
          nxt_st = (i_ee_data[7:4] == CHIP_CODE) ? S_LOAD : S_RUN;
        end else if (timeout) begin
          nxt_st = S_RUN;
        end
      end
      S_LOAD: begin
        if ((i_ee_ack && ee_addr_ff == LOAD_LAST) || timeout) begin
          nxt_st = S_RUN;
        end
      end
      S_RUN:   nxt_st = S_RUN;
      default: nxt_st = S_STRAP;
    endcase
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_ff <= S_STRAP;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Settle and answer-wait counter, restarted on every step
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wcnt_ff <= '0;
    end else if (nxt_st != st_ff || i_ee_ack) begin
      wcnt_ff <= '0;
    end else if (st_ff == S_STRAP || reading) begin
      wcnt_ff <= wcnt_ff + CW'(1);
    end
  end

  // Strap mode caught once after reset release
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mode_ff <= STRAP_AUTO;
    end else if (st_ff == S_STRAP && wcnt_ff == CW'(SYNC_SETTLE)) begin
      mode_ff <= strap_s2_ff;
    end
  end

  // EEPROM byte address
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ee_addr_ff <= EE_ADDR_ID0;
    end else if (st_ff == S_ID0 && i_ee_ack) begin
      ee_addr_ff <= EE_ADDR_ID1;
    end else if (st_ff == S_ID1 && i_ee_ack) begin
      ee_addr_ff <= EE_ADDR_FIRST;
    end else if (st_ff == S_LOAD && i_ee_ack) begin
      ee_addr_ff <= ee_addr_ff + 8'h01;
    end
  end

  // Outcome flags of the EEPROM attempt
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      absent_ff <= 1'h0;
      bad_ff    <= 1'h0;
      loaded_ff <= 1'h0;
    end else begin
      if (st_ff == S_ID0 && timeout) begin
        absent_ff <= 1'h1;
      end
      if (st_ff == S_ID0 && i_ee_ack && i_ee_data != FAMILY_CODE) begin
        bad_ff <= 1'h1;
      end
      if (st_ff == S_ID1 && i_ee_ack && i_ee_data[7:4] != CHIP_CODE) begin
        bad_ff <= 1'h1;
      end
      if (st_ff == S_LOAD && i_ee_ack && ee_addr_ff == LOAD_LAST) begin
        loaded_ff <= 1'h1;
      end
    end
  end

  // Forward each checked byte as a register write
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cfg_wr_ff   <= 1'h0;
      cfg_addr_ff <= 8'h00;
      cfg_data_ff <= 8'h00;
    end else begin
      cfg_wr_ff <= (st_ff == S_LOAD) && i_ee_ack;
      if (st_ff == S_LOAD && i_ee_ack) begin
        cfg_addr_ff <= ee_addr_ff;
        cfg_data_ff <= i_ee_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  // Run bit written by software
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      run_ff <= RUN_RST;
    end else if (wr_chip) begin
      run_ff <= i_reg_wdata[RUN_BIT];
    end
  end

  // Strap mode zero runs on its own; others need the run bit
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      swrun_ff <= 1'h0;
    end else begin
      swrun_ff <= (st_ff == S_RUN) && (mode_ff == STRAP_AUTO || run_ff);
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rdata_ff <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_FAMILY: rdata_ff <= FAMILY_CODE;
        ADDR_CHIP:   rdata_ff <= {CHIP_CODE, REVISION, run_ff};
        ADDR_STATUS: rdata_ff <= {4'h0, swrun_ff, loaded_ff, bad_ff, absent_ff};
        default:     rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign o_reg_rdata    = rdata_ff;
  assign o_ee_rd        = reading;
  assign o_ee_addr      = ee_addr_ff;
  assign o_cfg_wr       = cfg_wr_ff;
  assign o_cfg_addr     = cfg_addr_ff;
  assign o_cfg_data     = cfg_data_ff;
  assign o_use_defaults = !loaded_ff;
  assign o_switch_run   = swrun_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence seq_run_write;
    wr_chip && i_reg_wdata[RUN_BIT] && st_ff == S_WAIT_SW;
  endsequence

  sequence seq_start;
    ##[1:3] o_switch_run;
  endsequence

  chk_sw_start: assert property (seq_run_write |-> seq_start)
    else $error("switch did not start after run bit write");

  chk_stop_held: assert property (
    (st_ff != S_STRAP && mode_ff != STRAP_AUTO && !run_ff) |=> !o_switch_run)
    else $error("switch running with run bit zero");

  chk_auto_start: assert property (
    (st_ff == S_RUN && mode_ff == STRAP_AUTO) |=> o_switch_run)
    else $error("automatic start missing");

  chk_absent_dflt: assert property (
    (st_ff == S_ID0 && timeout) |=> absent_ff && st_ff == S_RUN ##1 o_switch_run)
    else $error("absent EEPROM not handled");

  chk_id_compare: assert property (
    (st_ff == S_ID1 && i_ee_ack && i_ee_data[7:4] == CHIP_CODE) |=> st_ff == S_LOAD)
    else $error("identification check did not pass");

  chk_load_write: assert property (
    (st_ff == S_LOAD && i_ee_ack) |=> o_cfg_wr && o_cfg_data == $past(i_ee_data))
    else $error("EEPROM byte not forwarded");

  chk_id_fields: assert property (
    (i_reg_rd && i_reg_addr == ADDR_CHIP) |=> o_reg_rdata[7:1] == {CHIP_CODE, REVISION})
    else $error("chip code or revision wrong");

  chk_bad_ignore: assert property (
    bad_ff |-> !o_cfg_wr && o_use_defaults && st_ff == S_RUN)
    else $error("failed EEPROM contents used");

endmodule

// [tb/cil_ee_model.sv]
module cil_ee_model (
  // Reader side
  input  wire logic       i_clk,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  // Scenario controls
  input  wire logic       i_present,
  input  wire logic [3:0] i_delay,
  // Answer
  output logic            o_ack,
  output logic      [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [256];
  logic [3:0] wait_cnt = 4'h0;
  logic       ack_q    = 1'b0;
  logic [7:0] data_q   = 8'h00;

  // ------------------------------------------------------------
  // Byte server
  // ------------------------------------------------------------
  // Answer after the set delay; data churns whenever no byte is offered
  always @(posedge i_clk) begin
    if (i_rd && i_present && !ack_q && wait_cnt >= i_delay) begin
      ack_q <= 1'b1;
      data_q <= mem[i_addr];
      wait_cnt <= 4'h0;
    end else begin
      ack_q <= 1'b0;
      data_q <= ~data_q;
      wait_cnt <= (i_rd && i_present && !ack_q) ? wait_cnt + 4'h1 : 4'h0;
    end
  end

  // One driver per answer signal
  assign o_ack  = ack_q;
  assign o_data = data_q;
endmodule

// [tb/cil_top_tb.sv]
module cil_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cil_pkg::*;

  localparam logic [7:0] FAM  = 8'hA5;
  localparam logic [3:0] CHIP = 4'h5;
  localparam logic [2:0] REV  = 3'h2;
  localparam logic [7:0] LAST = 8'h0B;

  logic       clk, rst, s_hi, s_lo, wr, rd, ee_rd, ee_ack, cfg_wr, use_def, run, present;
  logic [7:0] addr, wdata, rdata, ee_addr, ee_data, cfg_addr, cfg_data, got;
  logic [3:0] delay;
  int         errors, check_count, cfg_cnt;

  cil_top #(.FAMILY_CODE(FAM), .CHIP_CODE(CHIP), .REVISION(REV), .LOAD_LAST(LAST),
            .EE_WAIT(20)) dut_u (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_strap_mode_pin_high(s_hi),
    .i_strap_mode_pin_low(s_lo), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_ee_rd(ee_rd), .o_ee_addr(ee_addr),
    .i_ee_ack(ee_ack), .i_ee_data(ee_data), .o_cfg_wr(cfg_wr), .o_cfg_addr(cfg_addr),
    .o_cfg_data(cfg_data), .o_use_defaults(use_def), .o_switch_run(run));

  cil_ee_model ee_u (.i_clk(clk), .i_rd(ee_rd), .i_addr(ee_addr), .i_present(present),
    .i_delay(delay), .o_ack(ee_ack), .o_data(ee_data));

  // ------------------------------------------------------------
  // Clock, checks and bus tasks
  // ------------------------------------------------------------
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Forwarded bytes must come in ascending order from the first loadable address
  always @(posedge clk) begin
    if (cfg_wr === 1'b1) begin
      chk(cfg_addr, EE_ADDR_FIRST + 8'(cfg_cnt));
      chk(cfg_data, ee_u.mem[EE_ADDR_FIRST + 8'(cfg_cnt)]);
      cfg_cnt++;
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic do_reset(input logic [1:0] mode, input logic p, input logic [3:0] dl);
    @(posedge clk);
    rst <= 1'b1;
    {s_hi, s_lo} <= mode;
    present <= p;
    delay <= dl;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cfg_cnt = 0;
  endtask

  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (run !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    #1 chk({7'h00, run}, 8'h01);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Identity fields, read-only parts, unmapped place
  task automatic t_ident();
    do_reset(2'h1, 1'b0, 4'h0);
    reg_rd(ADDR_FAMILY);
    chk(got, FAM);
    reg_wr(ADDR_FAMILY, 8'h00);
    reg_wr(ADDR_CHIP, 8'h00);
    reg_rd(ADDR_FAMILY);
    chk(got, FAM);
    reg_rd(ADDR_CHIP);
    chk(got, {CHIP, REV, 1'b0});
    reg_rd(8'h7F);
    chk(got, 8'h00);
  endtask

  // Each software-start mode stays stopped until the run bit is set
  task automatic t_soft(input logic [1:0] mode);
    do_reset(mode, 1'b1, 4'h0);
    repeat (40) @(posedge clk);
    chk({7'h00, run}, 8'h00);
    reg_rd(ADDR_STATUS);
    chk(got, 8'h00);
    reg_wr(ADDR_CHIP, 8'hFF);
    reg_rd(ADDR_CHIP);
    chk(got, {CHIP, REV, 1'b1});
    wait_run(4);
    chk({7'h00, use_def}, 8'h01);
    chk(cfg_cnt[7:0], 8'h00);
  endtask

  // Automatic start with the store missing, rejected or accepted
  task automatic t_auto(input logic p, input logic [7:0] b0, input logic [7:0] b1,
                        input logic [7:0] n_wr, input logic dflt, input logic [7:0] sts);
    ee_u.mem[0] = b0;
    ee_u.mem[1] = b1;
    do_reset(2'h0, p, 4'h3);
    wait_run(200);
    chk(cfg_cnt[7:0], n_wr);
    chk({7'h00, use_def}, {7'h00, dflt});
    reg_rd(ADDR_STATUS);
    chk(got, sts);
  endtask

  // ------------------------------------------------------------
  // Main sequence and closing
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {rst, s_hi, s_lo, wr, rd, present} = 6'h20;
    {addr, wdata} = 16'h0000;
    delay = 4'h0;
    errors = 0;
    check_count = 0;
    cfg_cnt = 0;
    for (int i = 0; i < 256; i++) ee_u.mem[i] = 8'(i) ^ 8'h3C;
    t_ident();
    for (int m = 1; m < 4; m++) t_soft(2'(m));
    t_auto(1'b0, FAM, {CHIP, 4'h9}, 8'h00, 1'b1, 8'h09);
    t_auto(1'b1, FAM ^ 8'h01, {CHIP, 4'h0}, 8'h00, 1'b1, 8'h0A);
    t_auto(1'b1, FAM, {~CHIP, 4'h0}, 8'h00, 1'b1, 8'h0A);
    t_auto(1'b1, FAM, {CHIP, 4'hE}, LAST - 8'h01, 1'b0, 8'h0C);
    end_of_test();
  end

  // Watchdog well beyond the few hundred cycles the scenarios take
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule
